// ==== dtc_pkg.sv ====
/*
 * Package for the dual timer/counter unit: register map, field positions,
 * reset values, timing counts and shared types.
 * Assumes a single 10 MHz clock with one clock per oscillator period.
 */
package dtc_pkg;

	localparam int unsigned OSC_PER_MACHINE_CYCLE = 6;
	localparam int unsigned MC_CNT_W              = 3;

	localparam logic [7:0] ADDR_CONTROL    = 8'h88;
	localparam logic [7:0] ADDR_MODE       = 8'h89;
	localparam logic [7:0] ADDR_LOW_ZERO   = 8'h8A;
	localparam logic [7:0] ADDR_LOW_ONE    = 8'h8B;
	localparam logic [7:0] ADDR_HIGH_ZERO  = 8'h8C;
	localparam logic [7:0] ADDR_HIGH_ONE   = 8'h8D;

	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [7:0] COUNT_RESET     = 8'h00;

	localparam int unsigned QUAL_BIT_ONE   = 7;
	localparam int unsigned SRC_BIT_ONE    = 6;
	localparam int unsigned MODE_HI_ONE    = 5;
	localparam int unsigned MODE_LO_ONE    = 4;
	localparam int unsigned QUAL_BIT_ZERO  = 3;
	localparam int unsigned SRC_BIT_ZERO   = 2;
	localparam int unsigned MODE_HI_ZERO   = 1;
	localparam int unsigned MODE_LO_ZERO   = 0;

	localparam int unsigned FLAG_BIT_ONE   = 7;
	localparam int unsigned RUN_BIT_ONE    = 6;
	localparam int unsigned FLAG_BIT_ZERO  = 5;
	localparam int unsigned RUN_BIT_ZERO   = 4;

	localparam logic [4:0] PRESCALE_MAX    = 5'h1F;
	localparam logic [7:0] BYTE_MAX        = 8'hFF;

	typedef enum logic [1:0] {
		DTC_MODE_PRESCALE = 2'b00,
		DTC_MODE_SIXTEEN  = 2'b01,
		DTC_MODE_RELOAD   = 2'b10,
		DTC_MODE_SPLIT    = 2'b11
	} dtc_mode_type;

	typedef struct packed {
		logic         qualify;
		logic         external;
		dtc_mode_type mode;
	} dtc_ctrl_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dtc_bus_type;

endpackage

// ==== dtc_edge_detect.sv ====
/*
 * Falling-edge detector for an external count input.
 * Assumes the input is synchronous and sampleEn pulses once per machine cycle.
 */
`timescale 1ns/10ps
module dtc_edge_detect
	import dtc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic sampleEn,
	input  wire logic pinIn,
	output logic      fallSeen
);

	logic prevSample_q;
	logic curSample_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prevSample_q <= 1'b0;
			curSample_q  <= 1'b0;
		end else if (sampleEn) begin
			curSample_q  <= pinIn;
			prevSample_q <= curSample_q;
		end
	end

	// High in one sample, low in the next
	assign fallSeen = prevSample_q & ~curSample_q; // see RL2

endmodule

// ==== dtc_machine_cycle.sv ====
/*
 * Machine-cycle enable divider.
 * Assumes ref_clk is the oscillator clock.
 */
`timescale 1ns/10ps
module dtc_machine_cycle
	import dtc_pkg::*;
#(
	parameter int unsigned DIVIDE = OSC_PER_MACHINE_CYCLE
)
(
	input  wire logic ref_clk,
	input  wire logic reset,
	output logic      tick
);

	logic [MC_CNT_W-1:0] div_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			div_q <= '0;
			tick  <= 1'b0;
		end else begin
			tick <= (div_q == MC_CNT_W'(DIVIDE - 1)); // see RL1
			if (div_q == MC_CNT_W'(DIVIDE - 1)) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

endmodule

// ==== dtc_top.sv ====
/*
 * Dual timer/counter unit: two 16-bit timer/counters with four modes each,
 * mode register, control register and four count bytes on a plain port.
 * Assumes pins synchronous to ref_clk; read data one cycle after read strobe.
 */
`timescale 1ns/10ps
// Summary of operation
// RL1: timer counts once per six-clock machine cycle
// RL2: counter samples pin, counts falling edges
// RL3: new count visible next machine cycle
// RL4: edge recognition limits rate to one twelfth
// RL5: source holds each level one machine cycle
// RL6: source bit picks machine cycle or pin
// RL7: qualify bit gates counting by pin
// RL8: two-bit mode field per timer
// RL9: mode 00 five-bit prescaler before high byte
// RL10: mode 01 sixteen-bit cascaded counter
// RL11: mode 10 low byte reloads from high
// RL12: timer zero mode 11 splits two counters
// RL13: timer one mode 11 holds its count
// RL14: mode register at 89H, resets zero
// RL15: overflow sets flag, vector or software clears
// RL16: mode 0 count is thirteen bits
// RL17: run bit never clears count bytes
// RL18: reload leaves high byte unchanged
// RL19: software reads and writes count bytes anytime
module dtc_top
	import dtc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	input  wire logic       count_input_zero,
	input  wire logic       count_input_one,
	input  wire logic       qualify_pin_zero,
	input  wire logic       qualify_pin_one,
	input  wire logic       vectorAckZero,
	input  wire logic       vectorAckOne,
	output logic            overflowFlagZero,
	output logic            overflowFlagOne
);

	logic [7:0] timer_mode_control_q;
	logic [1:0] run_control_q;
	logic [7:0] count_low_byte_q [2];
	logic [7:0] count_high_byte_q [2];
	logic       machTick;
	logic [1:0] pinFall;
	logic [1:0] pinIn;
	logic [1:0] qualIn;
	logic [1:0] ackIn;
	logic [1:0] advance;
	logic [1:0] lowOvf;
	logic [1:0] highOvf;
	logic       splitHighAdv;
	logic       splitHighOvf;
	logic       splitActive;
	dtc_ctrl_type ctrl [2];

	assign pinIn  = {count_input_one, count_input_zero};
	assign qualIn = {qualify_pin_one, qualify_pin_zero};
	assign ackIn  = {vectorAckOne, vectorAckZero};

	// Field decode of the mode register
	function automatic dtc_ctrl_type unpack_ctrl(input logic [7:0] m, input logic one);
		dtc_ctrl_type c;
		c = '{qualify: 1'b0, external: 1'b0, mode: DTC_MODE_PRESCALE};
		if (one) begin
			c.qualify  = m[QUAL_BIT_ONE];
			c.external = m[SRC_BIT_ONE];
			c.mode     = dtc_mode_type'({m[MODE_HI_ONE], m[MODE_LO_ONE]});
		end else begin
			c.qualify  = m[QUAL_BIT_ZERO];
			c.external = m[SRC_BIT_ZERO];
			c.mode     = dtc_mode_type'({m[MODE_HI_ZERO], m[MODE_LO_ZERO]});
		end
		return c;
	endfunction

	function automatic logic is_write(input logic wr, input logic [7:0] a,
		input logic [7:0] target);
		return wr && (a == target);
	endfunction

	dtc_machine_cycle u_mc (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tick    (machTick)
	);

	assign splitActive = (ctrl[0].mode == DTC_MODE_SPLIT);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_unit
			logic gateOk;
			logic runEff;

			dtc_edge_detect u_edge (
				.ref_clk  (ref_clk),
				.reset    (reset),
				.sampleEn (machTick),
				.pinIn    (pinIn[gi]),
				.fallSeen (pinFall[gi])
			);

			assign ctrl[gi] = unpack_ctrl(timer_mode_control_q, gi == 1); // see RL8
			assign gateOk   = ~ctrl[gi].qualify | qualIn[gi]; // see RL7
			// Timer one loses its run bit to the split high byte; mode 11 stops it
			assign runEff = run_control_q[gi] & gateOk
				& ~((gi == 1) && (splitActive || ctrl[1].mode == DTC_MODE_SPLIT)); // see RL13
			// Pin edges are latched per machine cycle, so rate is capped at 1/12
			assign advance[gi] = machTick & runEff
				& (ctrl[gi].external ? pinFall[gi] : 1'b1); // see RL1 RL2 RL4 RL6

			always_comb begin
				lowOvf[gi]  = 1'b0;
				highOvf[gi] = 1'b0;
				unique case (ctrl[gi].mode)
					DTC_MODE_PRESCALE: begin
						lowOvf[gi]  = count_low_byte_q[gi][4:0] == PRESCALE_MAX; // see RL9
						highOvf[gi] = lowOvf[gi] && count_high_byte_q[gi] == BYTE_MAX;
					end
					DTC_MODE_SIXTEEN: begin
						lowOvf[gi]  = count_low_byte_q[gi] == BYTE_MAX; // see RL10
						highOvf[gi] = lowOvf[gi] && count_high_byte_q[gi] == BYTE_MAX;
					end
					DTC_MODE_RELOAD,
					DTC_MODE_SPLIT: begin
						lowOvf[gi]  = count_low_byte_q[gi] == BYTE_MAX;
						highOvf[gi] = lowOvf[gi];
					end
				endcase
			end

			// Count bytes: software write replaces the count at any time
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					count_low_byte_q[gi]  <= COUNT_RESET;
					count_high_byte_q[gi] <= COUNT_RESET;
				end else begin
					if (is_write(regWr, regAddr, gi ? ADDR_LOW_ONE : ADDR_LOW_ZERO)) begin
						count_low_byte_q[gi] <= regWdata; // see RL19
					end else if (advance[gi]) begin
						unique case (ctrl[gi].mode)
							DTC_MODE_PRESCALE: begin
								// Upper three bits are left as they are
								count_low_byte_q[gi][4:0] <= count_low_byte_q[gi][4:0] + 5'h01; // see RL16
							end
							DTC_MODE_SIXTEEN,
							DTC_MODE_SPLIT: begin
								count_low_byte_q[gi] <= count_low_byte_q[gi] + 8'h01; // see RL3
							end
							DTC_MODE_RELOAD: begin
								count_low_byte_q[gi] <= lowOvf[gi] ? count_high_byte_q[gi]
									: count_low_byte_q[gi] + 8'h01; // see RL11
							end
						endcase
					end
					if (is_write(regWr, regAddr, gi ? ADDR_HIGH_ONE : ADDR_HIGH_ZERO)) begin
						count_high_byte_q[gi] <= regWdata; // see RL19
					end else if (gi == 0 && splitActive) begin
						if (splitHighAdv) begin
							count_high_byte_q[gi] <= count_high_byte_q[gi] + 8'h01; // see RL12
						end
					end else if (advance[gi] && lowOvf[gi]
						&& ctrl[gi].mode inside {DTC_MODE_PRESCALE, DTC_MODE_SIXTEEN}) begin
						count_high_byte_q[gi] <= count_high_byte_q[gi] + 8'h01; // see RL18
					end
				end
			end
		end
	endgenerate

	// Split high byte always counts machine cycles under timer one's run bit
	assign splitHighAdv = splitActive & machTick & run_control_q[1]; // see RL12
	assign splitHighOvf = splitHighAdv & (count_high_byte_q[0] == BYTE_MAX);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timer_mode_control_q <= MODE_RESET; // see RL14
		end else if (is_write(regWr, regAddr, ADDR_MODE)) begin
			timer_mode_control_q <= regWdata;
		end
	end

	// Run bits only; writing them never touches the count bytes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run_control_q <= 2'b00;
		end else if (is_write(regWr, regAddr, ADDR_CONTROL)) begin
			run_control_q <= {regWdata[RUN_BIT_ONE], regWdata[RUN_BIT_ZERO]}; // see RL17
		end
	end

	// Overflow flags: hardware set wins over any clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			overflowFlagZero <= 1'b0;
			overflowFlagOne  <= 1'b0;
		end else begin
			if (advance[0] && highOvf[0]) begin
				overflowFlagZero <= 1'b1; // see RL15
			end else if (ackIn[0]) begin
				overflowFlagZero <= 1'b0;
			end else if (is_write(regWr, regAddr, ADDR_CONTROL)) begin
				overflowFlagZero <= regWdata[FLAG_BIT_ZERO];
			end
			if ((advance[1] && highOvf[1]) || splitHighOvf) begin
				overflowFlagOne <= 1'b1; // see RL15 RL12
			end else if (ackIn[1]) begin
				overflowFlagOne <= 1'b0;
			end else if (is_write(regWr, regAddr, ADDR_CONTROL)) begin
				overflowFlagOne <= regWdata[FLAG_BIT_ONE];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				ADDR_MODE:      regRdata <= timer_mode_control_q;
				ADDR_CONTROL:   regRdata <= {overflowFlagOne, run_control_q[1],
					overflowFlagZero, run_control_q[0], 4'h0};
				ADDR_LOW_ZERO:  regRdata <= count_low_byte_q[0];
				ADDR_LOW_ONE:   regRdata <= count_low_byte_q[1];
				ADDR_HIGH_ZERO: regRdata <= count_high_byte_q[0];
				ADDR_HIGH_ONE:  regRdata <= count_high_byte_q[1];
				default:        regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

endmodule

// ==== dtc_sva.sv ====
/* Port assertions for dtc_top.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/10ps
module dtc_sva
	import dtc_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       vectorAckZero,
	input wire logic       vectorAckOne,
	input wire logic       overflowFlagZero,
	input wire logic       overflowFlagOne
);
	logic ctlWr;
	logic clrZero;
	logic clrOne;
	logic unmapped;
	assign ctlWr = regWr && regAddr == ADDR_CONTROL;
	assign clrZero = ctlWr && !regWdata[FLAG_BIT_ZERO];
	assign clrOne = ctlWr && !regWdata[FLAG_BIT_ONE];
	assign unmapped = regAddr < ADDR_CONTROL || regAddr > ADDR_HIGH_ONE;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence modeWrite;
		regWr && regAddr == ADDR_MODE;
	endsequence
	sequence modeRead;
		regRd && regAddr == ADDR_MODE;
	endsequence
	AST_MODE_READBACK:
		assert property (modeWrite ##1 modeRead |=> regRdata == $past(regWdata, 2))
		else $error("mode readback mismatch");
	AST_READ_IDLE:
		assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside read cycle");
	AST_RESET_CLEAR:
		assert property ($past(reset) |-> !overflowFlagZero && !overflowFlagOne)
		else $error("flags not clear after reset");
	AST_UNMAPPED:
		assert property (regRd && unmapped |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	AST_FLAG_READ:
		assert property (regRd && regAddr == ADDR_CONTROL |=> regRdata[3:0] == 4'h0
			&& regRdata[7] == $past(overflowFlagOne) && regRdata[5] == $past(overflowFlagZero))
		else $error("control read wrong");
	AST_SET_ZERO:
		assert property (ctlWr && regWdata[FLAG_BIT_ZERO] |=> overflowFlagZero)
		else $error("flag zero not set by write");
	AST_SET_ONE:
		assert property (ctlWr && regWdata[FLAG_BIT_ONE] |=> overflowFlagOne)
		else $error("flag one not set by write");
	AST_FALL_ZERO:
		assert property ($fell(overflowFlagZero) |-> $past(vectorAckZero) || $past(clrZero))
		else $error("flag zero fell without cause");
	AST_FALL_ONE:
		assert property ($fell(overflowFlagOne) |-> $past(vectorAckOne) || $past(clrOne))
		else $error("flag one fell without cause");
endmodule
bind dtc_top dtc_sva u_sva (.ref_clk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
	.vectorAckZero, .vectorAckOne, .overflowFlagZero, .overflowFlagOne);

// ==== dtc_pins.sv ====
/* Model of the external count and qualify sources.
   Assumes its pins are sampled on ref_clk rising edges. */
`timescale 1ns/10ps
module dtc_pins (
	input  wire logic ref_clk,
	output logic      countZero,
	output logic      countOne,
	output logic      qualZero,
	output logic      qualOne
);
	initial begin
		countZero = 1'b1;
		countOne = 1'b1;
		qualZero = 1'b0;
		qualOne = 1'b0;
	end
	task automatic qualify(input logic z, input logic o);
		@(posedge ref_clk);
		qualZero <= z;
		qualOne <= o;
	endtask
	// Levels held two machine cycles, above the one-cycle minimum
	task automatic burst(input int n);
		repeat (n) begin
			repeat (12) @(posedge ref_clk);
			countZero <= 1'b0;
			countOne <= 1'b0;
			repeat (12) @(posedge ref_clk);
			countZero <= 1'b1;
			countOne <= 1'b1;
		end
	endtask
endmodule

// ==== dtc_top_tb.sv ====
/* Self-checking bench for dtc_top: registers, timer modes, pin counting.
   Assumes dtc_sva is bound to the design and dtc_pins drives the pins. */
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module dtc_top_tb
	import dtc_pkg::*;
;
	logic       ref_clk;
	logic       reset;
	logic       regWr;
	logic       regRd;
	logic       vectorAckZero;
	logic       vectorAckOne;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic       overflowFlagZero;
	logic       overflowFlagOne;
	logic       cntZero;
	logic       cntOne;
	logic       qualZero;
	logic       qualOne;
	int         n_errors = 0;
	int         n_compared = 0;
	dtc_top dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .count_input_zero(cntZero),
		.count_input_one(cntOne), .qualify_pin_zero(qualZero), .qualify_pin_one(qualOne),
		.vectorAckZero(vectorAckZero), .vectorAckOne(vectorAckOne),
		.overflowFlagZero(overflowFlagZero), .overflowFlagOne(overflowFlagOne));
	dtc_pins pins (.ref_clk(ref_clk), .countZero(cntZero), .countOne(cntOne),
		.qualZero(qualZero), .qualOne(qualOne));
	always #50 ref_clk = ~ref_clk;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		`CHK(nm, e, regRdata)
	endtask
	// Run exactly 60 clocks so any divider phase yields ten ticks
	task automatic run(input logic [7:0] ctl, input logic f0, input logic f1);
		wr(ADDR_CONTROL, ctl);
		repeat (57) @(posedge ref_clk);
		#1;
		`CHK("flag zero", f0, overflowFlagZero)
		`CHK("flag one", f1, overflowFlagOne)
		@(posedge ref_clk);
		vectorAckZero <= 1'b1;
		vectorAckOne <= 1'b1;
		@(posedge ref_clk);
		{vectorAckZero, vectorAckOne} <= 2'b00;
		{regWr, regAddr, regWdata} <= {1'b1, ADDR_CONTROL, 8'h00};
		#1;
		`CHK("ack clears", 2'b00, {overflowFlagZero, overflowFlagOne})
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic t_regs;
		for (int a = 8'h88; a <= 8'h8D; a++) rd(8'(a), 8'h00, "reset value");
		rd(8'h90, 8'h00, "unmapped");
		wr(ADDR_MODE, 8'hA5);
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		`CHK("mode", 8'hA5, regRdata)
		wr(ADDR_HIGH_ONE, 8'h5A);
		rd(ADDR_HIGH_ONE, 8'h5A, "high one");
		wr(ADDR_CONTROL, 8'hA0);
		rd(ADDR_CONTROL, 8'hA0, "flags set");
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_CONTROL, 8'h00, "flags clear");
		$display("test regs done");
	endtask
	task automatic t_timer;
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_HIGH_ZERO, 8'hFF);
		wr(ADDR_LOW_ZERO, 8'hFA);
		wr(ADDR_HIGH_ONE, 8'h00);
		wr(ADDR_LOW_ONE, 8'h1E);
		run(8'h50, 1'b1, 1'b0);
		rd(ADDR_LOW_ZERO, 8'h04, "sixteen low");
		rd(ADDR_HIGH_ZERO, 8'h00, "sixteen high");
		rd(ADDR_LOW_ONE, 8'h08, "prescale low");
		rd(ADDR_HIGH_ONE, 8'h01, "prescale high");
		wr(ADDR_MODE, 8'h02);
		wr(ADDR_HIGH_ZERO, 8'hF0);
		wr(ADDR_LOW_ZERO, 8'hFC);
		run(8'h10, 1'b1, 1'b0);
		rd(ADDR_LOW_ZERO, 8'hF6, "reload low");
		rd(ADDR_HIGH_ZERO, 8'hF0, "reload high");
		$display("test timer modes done");
	endtask
	task automatic t_split;
		wr(ADDR_MODE, 8'h33);
		wr(ADDR_LOW_ZERO, 8'h00);
		// Split high byte wraps on the eighth tick, raising flag one
		wr(ADDR_HIGH_ZERO, 8'hF8);
		wr(ADDR_LOW_ONE, 8'h05);
		run(8'h50, 1'b0, 1'b1);
		rd(ADDR_LOW_ZERO, 8'h0A, "split low");
		rd(ADDR_HIGH_ZERO, 8'h02, "split high");
		rd(ADDR_LOW_ONE, 8'h05, "held");
		$display("test split done");
	endtask
	task automatic t_count;
		wr(ADDR_MODE, 8'h4D);
		wr(ADDR_LOW_ZERO, 8'h00);
		wr(ADDR_LOW_ONE, 8'h00);
		pins.qualify(1'b1, 1'b0);
		wr(ADDR_CONTROL, 8'h50);
		pins.burst(3);
		repeat (24) @(posedge ref_clk);
		rd(ADDR_LOW_ZERO, 8'h03, "edges zero");
		rd(ADDR_LOW_ONE, 8'h03, "edges one");
		pins.qualify(1'b0, 1'b0);
		pins.burst(3);
		repeat (24) @(posedge ref_clk);
		rd(ADDR_LOW_ZERO, 8'h03, "gated zero");
		rd(ADDR_LOW_ONE, 8'h06, "ungated one");
		wr(ADDR_CONTROL, 8'h00);
		$display("test counting done");
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		{regWr, regRd, vectorAckZero, vectorAckOne} = 4'h0;
		{regAddr, regWdata} = 16'h0000;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs;
		t_timer;
		t_split;
		t_count;
		summarize;
	end
	// Tests need about 500 clocks; forty times that is a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		summarize;
	end
endmodule
